// [oapu_pkg.sv]
`default_nettype none
package oapu_pkg;
    // ----------------------------------------------------------------
    // Data path shape
    // ----------------------------------------------------------------
    localparam int          OAPU_WORD_W     = 16;
    localparam int          OAPU_FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // Register map: printed offsets are word indices, byte address = 4x
    // ----------------------------------------------------------------
    localparam logic [11:0] OAPU_IDX_OVL_FMT   = 12'h832;
    localparam logic [11:0] OAPU_IDX_DISP_MODE = 12'h834;
    localparam logic [31:0] OAPU_ADDR_OVL_FMT   = {18'h00000, OAPU_IDX_OVL_FMT, 2'b00};
    localparam logic [31:0] OAPU_ADDR_DISP_MODE = {18'h00000, OAPU_IDX_DISP_MODE, 2'b00};

    // Reset values and implemented bits (others read as zero)
    localparam logic [15:0] OAPU_OVL_FMT_RST    = 16'h0000;
    localparam logic [15:0] OAPU_DISP_MODE_RST  = 16'h0000;
    localparam logic [15:0] OAPU_OVL_FMT_MASK   = 16'h0f00;
    localparam logic [15:0] OAPU_DISP_MODE_MASK = 16'h0707;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          OAPU_ALPHA_SEL_BIT = 11;
    localparam int          OAPU_DEPTH_LSB     = 8;
    localparam int          OAPU_VROT_LSB      = 0;
    localparam int          OAPU_VMIR_BIT      = 2;
    localparam int          OAPU_OROT_LSB      = 8;
    localparam int          OAPU_OMIR_BIT      = 10;

    // Pixel depth codes used with the alpha format select set
    localparam logic [2:0]  OAPU_DEPTH_A1555 = 3'h1;
    localparam logic [2:0]  OAPU_DEPTH_A4444 = 3'h2;
    localparam logic [2:0]  OAPU_DEPTH_A8888 = 3'h4;

    // Opaque alpha for plain colour pixels
    localparam logic [7:0]  OAPU_ALPHA_OPAQUE = 8'hff;

    // Bus answers
    localparam logic [1:0]  OAPU_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  OAPU_RESP_SLVERR = 2'h2;

    // Register selection after address decode
    localparam logic [1:0]  OAPU_SEL_NONE = 2'h0;
    localparam logic [1:0]  OAPU_SEL_FMT  = 2'h1;
    localparam logic [1:0]  OAPU_SEL_MODE = 2'h2;

    // Which half of a 32-bit alpha pixel comes next
    typedef enum logic {OAPU_PAIR_LOW, OAPU_PAIR_HIGH} oapu_pair_t;
endpackage
`default_nettype wire

// [oapu_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module oapu_fifo
    import oapu_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstN,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];     // Word storage
    logic [AW:0]      wrPtr;           // Write pointer with wrap bit
    logic [AW:0]      rdPtr;           // Read pointer with wrap bit
    logic [AW:0]      level;           // Words held
    logic             spaceAvail;      // Registered not-full
    logic             dataAvail;       // Registered not-empty
    logic [AW:0]      next_level;

    wire push = inValid && spaceAvail;
    wire pop  = dataAvail && outReady;

    assign inReady  = spaceAvail;
    assign outValid = dataAvail;
    assign outData  = mem[rdPtr[AW-1:0]];
    assign next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // ----------------------------------------------------------------
    // Pointers and flags; flags are registered so ready is glitch free
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wrPtr      <= '0;
            rdPtr      <= '0;
            level      <= '0;
            spaceAvail <= 1'b1;
            dataAvail  <= 1'b0;
        end
        else
        begin
            wrPtr      <= wrPtr + {{AW{1'b0}}, push};
            rdPtr      <= rdPtr + {{AW{1'b0}}, pop};
            level      <= next_level;
            spaceAvail <= (next_level != (AW + 1)'(DEPTH));
            dataAvail  <= (next_level != '0);
        end
    end

    // Storage needs no reset; only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule
`default_nettype wire

// [oapu_unpacker.sv]
// Summary of operation
// - One select bit chooses alpha or plain colour
// - Three-bit depth field picks the exact format
// - 1:5:5:5 alpha bit15, colours five bits each
// - 4:4:4:4 alpha top nibble, then red, green, blue
// - 32-bit: low word green/blue, high alpha/red
// - Decoded alpha goes on to blending
// - Rotation and mirror for both windows, one register
// - Rotation: viewport bits 1-0, overlay bits 9-8
// - Mirror: viewport bit 2, overlay bit 10
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module oapu_unpacker
    import oapu_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // AXI4-Lite write address and data
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Fetched display buffer words
    input  wire logic        wordValid,
    input  wire logic [15:0] wordData,
    output logic             wordReady,
    // Decoded overlay pixels
    output logic             pixValid,
    input  wire logic        pixReady,
    output logic             pixAlphaMode,
    output logic [7:0]       pixAlpha,
    output logic [7:0]       pixRed,
    output logic [7:0]       pixGreen,
    output logic [7:0]       pixBlue,
    // Rotation and mirror controls
    output logic [1:0]       viewRotate,
    output logic             viewMirror,
    output logic [1:0]       ovlRotate,
    output logic             ovlMirror
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] oapu_decode(input logic [31:0] addr);
        oapu_decode = (addr == OAPU_ADDR_OVL_FMT)   ? OAPU_SEL_FMT  :
                      (addr == OAPU_ADDR_DISP_MODE) ? OAPU_SEL_MODE : OAPU_SEL_NONE;
    endfunction

    // Byte-lane merge limited to implemented bits
    function automatic logic [15:0] oapu_merge(input logic [15:0] old, input logic [15:0] data,
                                               input logic [1:0] strb, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes      = {{8{strb[1]}}, {8{strb[0]}}};
        oapu_merge = ((old & ~lanes) | (data & lanes)) & mask;
    endfunction

    // Widen a five-bit component by repeating its top bits
    function automatic logic [7:0] oapu_wide5(input logic [4:0] v);
        oapu_wide5 = {v, v[4:2]};
    endfunction

    // ----------------------------------------------------------------
    // Reset release through two flops
    // ----------------------------------------------------------------
    logic rstMeta;                     // First stage, read by rstN only
    logic rstN;                        // Released reset for the block

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            {rstN, rstMeta} <= 2'b00;
        else
            {rstN, rstMeta} <= {rstMeta, 1'b1};
    end

    // ----------------------------------------------------------------
    // Register bus slave
    // ----------------------------------------------------------------
    logic [15:0] ovlFmt;               // Overlay format configuration
    logic [15:0] dispMode;             // Display mode setting two
    logic [31:0] awAddrHeld;           // Captured write address
    logic [15:0] wDataHeld;            // Captured write data, low half
    logic [1:0]  wStrbHeld;            // Captured lanes of low half

    // Both halves held and no response pending: commit the write
    wire       doWrite = !awready && !wready && !bvalid;
    wire [1:0] wrSel   = oapu_decode(awAddrHeld);
    wire [1:0] rdSel   = oapu_decode(araddr);
    wire       wrFmt   = doWrite && (wrSel == OAPU_SEL_FMT);
    wire       wrMode  = doWrite && (wrSel == OAPU_SEL_MODE);
    wire [15:0] rdWord = (rdSel == OAPU_SEL_FMT)  ? ovlFmt   :
                         (rdSel == OAPU_SEL_MODE) ? dispMode : 16'h0000;

    // Address and data are taken in either order; ready drops while held
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            {awready, wready, awAddrHeld, wDataHeld, wStrbHeld} <= {2'b11, 50'h0};
        else if (doWrite)
            {awready, wready} <= 2'b11;
        else
        begin
            if (awvalid && awready)
            begin
                awAddrHeld <= awaddr;
                awready    <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wDataHeld <= wdata[15:0];
                wStrbHeld <= wstrb[1:0];
                wready    <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            {bvalid, bresp} <= {1'b0, OAPU_RESP_OKAY};
        else if (doWrite)
        begin
            bvalid <= 1'b1;
            bresp  <= (wrSel == OAPU_SEL_NONE) ? OAPU_RESP_SLVERR : OAPU_RESP_OKAY;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // Control registers; a format write also realigns word pairing
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            ovlFmt   <= OAPU_OVL_FMT_RST;
            dispMode <= OAPU_DISP_MODE_RST;
        end
        else
        begin
            if (wrFmt)
                ovlFmt <= oapu_merge(ovlFmt, wDataHeld, wStrbHeld, OAPU_OVL_FMT_MASK);
            if (wrMode)
                dispMode <= oapu_merge(dispMode, wDataHeld, wStrbHeld, OAPU_DISP_MODE_MASK);
        end
    end

    // Read channel answers on the same edge that takes the address
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            {arready, rvalid, rdata, rresp} <= {1'b1, 33'h0, OAPU_RESP_OKAY};
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {16'h0000, rdWord};
            rresp   <= (rdSel == OAPU_SEL_NONE) ? OAPU_RESP_SLVERR : OAPU_RESP_OKAY;
        end
        else if (rvalid && rready)
            {arready, rvalid} <= 2'b10;
    end

    // Rotation and mirror enables come straight from the mode register
    assign viewRotate = dispMode[OAPU_VROT_LSB +: 2];
    assign ovlRotate  = dispMode[OAPU_OROT_LSB +: 2];
    assign viewMirror = dispMode[OAPU_VMIR_BIT];
    assign ovlMirror  = dispMode[OAPU_OMIR_BIT];

    // ----------------------------------------------------------------
    // Word buffer between fetch and decode
    // ----------------------------------------------------------------
    logic        fifoValid;            // Word waiting for decode
    logic [15:0] fifoData;             // Word at the head
    logic        fifoReady;            // Decode takes the head word

    oapu_fifo #(
        .WIDTH (OAPU_WORD_W),
        .DEPTH (OAPU_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk_sys),
        .rstN     (rstN),
        .inValid  (wordValid),
        .inReady  (wordReady),
        .inData   (wordData),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoData)
    );

    // ----------------------------------------------------------------
    // Format decode
    // ----------------------------------------------------------------
    oapu_pair_t  pairState;            // Expected half of a 32-bit pixel
    logic [15:0] lowHeld;              // Green and blue of a 32-bit pixel

    wire       fmtAlpha = ovlFmt[OAPU_ALPHA_SEL_BIT];
    wire [2:0] depth    = ovlFmt[OAPU_DEPTH_LSB +: 3];
    wire       is1555   = fmtAlpha && (depth == OAPU_DEPTH_A1555);
    wire       is4444   = fmtAlpha && (depth == OAPU_DEPTH_A4444);
    wire       is8888   = fmtAlpha && (depth == OAPU_DEPTH_A8888);
    // Unknown depth codes fall back to opaque pass-through
    wire       isAlpha  = is1555 || is4444 || is8888;
    // Output slot frees up when empty or being drained this edge
    wire       outFree  = !pixValid || pixReady;
    wire       take     = fifoValid && outFree;
    // The low word of a 32-bit pixel is consumed without output
    wire       emit     = take && !(is8888 && (pairState == OAPU_PAIR_LOW));
    assign fifoReady    = outFree;

    wire [7:0] decA = is1555 ? {8{fifoData[15]}} :
                      is4444 ? {fifoData[15:12], fifoData[15:12]} :
                      is8888 ? fifoData[15:8] : OAPU_ALPHA_OPAQUE;
    wire [7:0] decR = is1555 ? oapu_wide5(fifoData[14:10]) :
                      is4444 ? {fifoData[11:8], fifoData[11:8]} :
                      is8888 ? fifoData[7:0] : 8'h00;
    wire [7:0] decG = is1555 ? oapu_wide5(fifoData[9:5]) :
                      is4444 ? {fifoData[7:4], fifoData[7:4]} :
                      is8888 ? lowHeld[15:8] : fifoData[15:8];
    wire [7:0] decB = is1555 ? oapu_wide5(fifoData[4:0]) :
                      is4444 ? {fifoData[3:0], fifoData[3:0]} :
                      is8888 ? lowHeld[7:0] : fifoData[7:0];

    // Pairing of 32-bit pixels: low word first, then high word
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            pairState <= OAPU_PAIR_LOW;
            lowHeld   <= 16'h0000;
        end
        else if (wrFmt)
            pairState <= OAPU_PAIR_LOW;
        else if (take && is8888)
        begin
            case (pairState)
                OAPU_PAIR_LOW:
                begin
                    lowHeld   <= fifoData;
                    pairState <= OAPU_PAIR_HIGH;
                end
                OAPU_PAIR_HIGH:
                    pairState <= OAPU_PAIR_LOW;
                default:
                    pairState <= OAPU_PAIR_LOW;
            endcase
        end
    end

    // Output stage holds a pixel until the blender takes it
    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
            {pixValid, pixAlphaMode, pixAlpha, pixRed, pixGreen, pixBlue} <= 34'h0;
        else if (emit)
        begin
            pixValid     <= 1'b1;
            pixAlphaMode <= isAlpha;
            pixAlpha     <= decA;
            pixRed       <= decR;
            pixGreen     <= decG;
            pixBlue      <= decB;
        end
        else if (pixReady)
            pixValid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    fmt_select_a: assert property (wrFmt && wStrbHeld[1] |=> ovlFmt[11] == $past(wDataHeld[11]))
        else $error("format select not stored");
    depth_field_a: assert property (wrFmt && wStrbHeld[1] |=> ovlFmt[10:8] == $past(wDataHeld[10:8]))
        else $error("depth field not stored");
    a1555_decode_a: assert property (emit && is1555 |=> pixAlpha == {8{$past(fifoData[15])}}
        && pixRed[7:3] == $past(fifoData[14:10]) && pixGreen[7:3] == $past(fifoData[9:5])
        && pixBlue[7:3] == $past(fifoData[4:0]))
        else $error("1:5:5:5 fields misplaced");
    a4444_decode_a: assert property (emit && is4444 |=> pixAlpha[7:4] == $past(fifoData[15:12])
        && pixRed[7:4] == $past(fifoData[11:8]) && pixGreen[7:4] == $past(fifoData[7:4])
        && pixBlue[7:4] == $past(fifoData[3:0]))
        else $error("4:4:4:4 fields misplaced");
    a8888_pair_a: assert property (emit && is8888 |=> pixGreen == $past(lowHeld[15:8])
        && pixBlue == $past(lowHeld[7:0]) && pixAlpha == $past(fifoData[15:8])
        && pixRed == $past(fifoData[7:0]))
        else $error("32-bit pixel halves misplaced");
    low_word_silent_a: assert property (take && is8888 && pairState == OAPU_PAIR_LOW
        |=> pairState == OAPU_PAIR_HIGH && lowHeld == $past(fifoData) && !$rose(pixValid))
        else $error("low word produced a pixel");
    alpha_mode_a: assert property (emit |=> pixAlphaMode == $past(isAlpha)
        && (pixAlphaMode || pixAlpha == OAPU_ALPHA_OPAQUE))
        else $error("alpha mode flag wrong");
    view_ctrl_a: assert property (wrMode && wStrbHeld[0] |=> viewRotate == $past(wDataHeld[1:0])
        && viewMirror == $past(wDataHeld[2]))
        else $error("viewport rotate or mirror wrong");
    ovl_ctrl_a: assert property (wrMode && wStrbHeld[1] |=> ovlRotate == $past(wDataHeld[9:8])
        && ovlMirror == $past(wDataHeld[10]))
        else $error("overlay rotate or mirror wrong");
    mode_iso_a: assert property (wrFmt |=> $stable(dispMode))
        else $error("format write touched mode register");
    reset_zero_a: assert property ($rose(rstN) |-> ovlFmt == 16'h0000 && dispMode == 16'h0000)
        else $error("control registers not zero after reset");
    pix_hold_a: assert property (pixValid && !pixReady |=> pixValid && $stable(pixAlpha) && $stable(pixRed))
        else $error("pixel dropped under back-pressure");
    write_resp_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write answer late");

    c_1555_c: cover property (emit && is1555);
    c_4444_c: cover property (emit && is4444);
    c_8888_c: cover property (emit && is8888);
    c_full_c: cover property (!wordReady ##1 pixReady);
    c_unmap_c: cover property (bvalid && bresp == OAPU_RESP_SLVERR);
endmodule
`default_nettype wire

// [oapu_fetch_model.sv]
`timescale 1ns/10ps
`default_nettype none
module oapu_fetch_model
(
    // Clock
    input  wire logic        clk_sys,
    // Word source towards the unpacker
    output logic             wordValid,
    output logic [15:0]      wordData,
    input  wire logic        wordReady,
    // Pixel sink, packed as mode, alpha, red, green, blue
    input  wire logic        pixValid,
    input  wire logic [32:0] pixBits,
    output logic             pixReady,
    input  wire logic        stall
);
    // ----------------------------------------------------------------
    // Queues filled and emptied by the bench
    // ----------------------------------------------------------------
    logic [15:0] words[$];   // Words still to be offered
    logic [32:0] pixels[$];  // Pixels taken from the unpacker

    initial
    begin
        wordValid = 1'b0;
        wordData  = 16'h0000;
        pixReady  = 1'b0;
    end

    // Offer words one by one; hold each until it is taken
    always @(posedge clk_sys)
    begin
        if (pixValid && pixReady)
            pixels.push_back(pixBits);
        pixReady <= !stall;
        if (!wordValid || wordReady)
        begin
            wordValid <= (words.size() != 0);
            // Released data toggles so a stale word never looks valid
            if (words.size() != 0)
                wordData <= words.pop_front();
            else
                wordData <= ~wordData;
        end
    end
endmodule
`default_nettype wire

// [overlay_argb_pixel_unpacker_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module overlay_argb_pixel_unpacker_tb
    import oapu_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic        stall, hold, sawFull;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb, md, wsel;
    logic        awready, wready, bvalid, arready, rvalid, wordValid, wordReady, pixReady;
    logic        pixValid, pixAlphaMode, viewMirror, ovlMirror;
    logic [1:0]  bresp, rresp, viewRotate, ovlRotate, rsp;
    logic [15:0] wordData, wv, wq[$];
    logic [7:0]  pixAlpha, pixRed, pixGreen, pixBlue;
    int          n_mismatch, compares, cyc, np;
    logic [3:0]  modes[5] = '{4'h9, 4'ha, 4'hc, 4'h1, 4'hb};

    oapu_unpacker u_dut (.clk_sys, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .wordValid, .wordData, .wordReady, .pixValid, .pixReady, .pixAlphaMode,
        .pixAlpha, .pixRed, .pixGreen, .pixBlue, .viewRotate, .viewMirror, .ovlRotate, .ovlMirror);
    oapu_fetch_model u_fetch (.clk_sys, .wordValid, .wordData, .wordReady, .pixValid,
        .pixBits({pixAlphaMode, pixAlpha, pixRed, pixGreen, pixBlue}), .pixReady, .stall);

    // ----------------------------------------------------------------
    // Clock, sink stalls, full watch and hang limit
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        stall <= hold || ($urandom_range(3) == 0);
        sawFull <= sawFull || !wordReady;
        cyc = cyc + 1;
        // A few hundred cycles are expected; this is far beyond
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Write: address and data together, each released once taken
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= wsel;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Expected pixel from select/depth and the low and high words
    function automatic logic [32:0] expPix(input logic [3:0] m, input logic [15:0] lo, hi);
        logic [4:0] r5, g5, b5;
        r5 = hi[14:10];
        g5 = hi[9:5];
        b5 = hi[4:0];
        if (m == {1'b1, OAPU_DEPTH_A1555})
            return {1'b1, {8{hi[15]}}, r5, r5[4:2], g5, g5[4:2], b5, b5[4:2]};
        if (m == {1'b1, OAPU_DEPTH_A4444})
            return {1'b1, {2{hi[15:12]}}, {2{hi[11:8]}}, {2{hi[7:4]}}, {2{hi[3:0]}}};
        if (m == {1'b1, OAPU_DEPTH_A8888})
            return {1'b1, hi, lo};
        return {1'b0, OAPU_ALPHA_OPAQUE, 8'h00, hi};
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {nrst, awvalid, wvalid, bready, arvalid, rready, hold, sawFull} = '0;
        {awaddr, wdata, araddr} = '0;
        {wstrb, wsel} = 8'h0f;
        n_mismatch = 0;
        compares = 0;
        cyc = 0;
        rd = $urandom(555);
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        axr(OAPU_ADDR_OVL_FMT, rd, rsp);
        chk(rd, 64'h0);
        axr(OAPU_ADDR_DISP_MODE, rd, rsp);
        chk(rd, 64'h0);
        // Rotation and mirror fields, all ones first
        for (int i = 0; i < 4; i++)
        begin
            wv = (i == 0) ? 16'hffff : 16'($urandom);
            axw(OAPU_ADDR_DISP_MODE, {16'h0, wv}, rsp);
            axr(OAPU_ADDR_DISP_MODE, rd, rsp);
            chk(rd, {16'h0, wv & OAPU_DISP_MODE_MASK});
            chk({ovlMirror, ovlRotate, viewMirror, viewRotate}, {wv[10:8], wv[2:0]});
        end
        // Low lane only: overlay fields keep their last value
        wsel = 4'h1;
        axw(OAPU_ADDR_DISP_MODE, 32'h0, rsp);
        wsel = 4'hf;
        axr(OAPU_ADDR_DISP_MODE, rd, rsp);
        chk({rsp, rd}, {OAPU_RESP_OKAY, 16'h0, wv & OAPU_DISP_MODE_MASK & 16'hff00});
        chk({ovlMirror, ovlRotate, viewMirror, viewRotate}, {wv[10:8], 3'h0});
        // Unmapped place is refused both ways
        axw(32'h0000_0010, 32'h0000_ffff, rsp);
        chk(rsp, OAPU_RESP_SLVERR);
        axr(32'h0000_0010, rd, rsp);
        chk({rsp, rd}, {OAPU_RESP_SLVERR, 32'h0});
        // Every alpha layout, then two plain colour settings
        for (int m = 0; m < 5; m++)
        begin
            md = modes[m];
            hold <= (m == 0);
            axw(OAPU_ADDR_OVL_FMT, {20'h0, md, 8'h00}, rsp);
            axr(OAPU_ADDR_OVL_FMT, rd, rsp);
            chk(rd, {20'h0, md, 8'h00});
            u_fetch.pixels.delete();
            wq.delete();
            for (int k = 0; k < 12; k++)
            begin
                wq.push_back(16'($urandom));
                u_fetch.words.push_back(wq[k]);
            end
            // Sink stalled: the buffer must fill and push back
            if (m == 0)
            begin
                repeat (40) @(posedge clk_sys);
                chk(sawFull, 1'b1);
                hold <= 1'b0;
            end
            np = (md == 4'hc) ? 6 : 12;
            while (u_fetch.pixels.size() < np)
                @(posedge clk_sys);
            for (int k = 0; k < np; k++)
                chk(u_fetch.pixels[k], (np == 6) ? expPix(md, wq[2*k], wq[2*k+1])
                                                 : expPix(md, wq[k], wq[k]));
        end
        end_sim();
    end
endmodule
`default_nettype wire
